// >>> design/mmic_map.svh
// register map, field positions, reset values and timing for the two-wire bus controller
`ifndef MMIC_MAP_SVH
`define MMIC_MAP_SVH

`define MMIC_CTL_ADDR 32'h5400_0000
`define MMIC_STAT_ADDR 32'h5400_0004
`define MMIC_OWN_ADDR 32'h5400_0008
`define MMIC_DATA_ADDR 32'h5400_000c

`define MMIC_CTL_ACK 7
`define MMIC_CTL_CLKSEL 6
`define MMIC_CTL_INTEN 5
`define MMIC_CTL_PEND 4
`define MMIC_CTL_PRESC 3:0
`define MMIC_STAT_MODE 7:6
`define MMIC_STAT_BUSY 5
`define MMIC_STAT_SOUT 4
`define MMIC_STAT_ARB 3
`define MMIC_STAT_ASLV 2
`define MMIC_STAT_GCALL 1
`define MMIC_STAT_LAST 0

`define MMIC_CTL_RESET 8'h00
`define MMIC_STAT_RESET 8'h00
`define MMIC_OWN_RESET 7'h00
`define MMIC_DATA_RESET 8'h00

`define MMIC_DIV_FAST 16
`define MMIC_DIV_SLOW 512

`endif

// >>> design/mmic_pkg.sv
// types shared by the two-wire bus controller
package mmic_pkg;

   // one register port request, all fields sampled on the same edge
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mmic_bus_req_t;

   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_START = 4'h2,
      M_RUN = 4'h4,
      M_STOP = 4'h8
   } mmic_mstate_t;

endpackage

// >>> design/mmic_regs.sv
// register block and byte engine of the multi-master two-wire bus controller
`include "mmic_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mmic_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire mmic_pkg::mmic_bus_req_t busReq,
   output logic [31:0] readData,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic irq
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic ackEn;
   logic clkSel;
   logic intEn;
   logic pending;
   logic [3:0] presc;
   logic [1:0] mode;
   logic busy;
   logic soutEn;
   logic arbLost;
   logic asSlave;
   logic genCall;
   logic lastBit;
   logic [6:0] ownAddr;
   logic [7:0] shReg;

   // engine state
   mmic_pkg::mmic_mstate_t mState;
   logic [3:0] bitCnt;
   logic [3:0] pcnt;
   logic [8:0] srcCnt;
   logic mSclLow;
   logic sdaLow;
   logic engaged;
   logic addrPhase;
   logic waitData;
   logic stopReq;
   logic stallQ;
   logic sclPrev;
   logic sdaPrev;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire selCtl = busReq.addr == `MMIC_CTL_ADDR;
   wire selStat = busReq.addr == `MMIC_STAT_ADDR;
   wire selOwn = busReq.addr == `MMIC_OWN_ADDR;
   wire selData = busReq.addr == `MMIC_DATA_ADDR;
   wire [7:0] wByte = busReq.wdata[7:0];
   wire wrCtl = busReq.wr & selCtl;
   wire wrStat = busReq.wr & selStat;
   wire wrOwn = busReq.wr & selOwn;
   wire wrData = busReq.wr & selData;
   wire rdData = busReq.rd & selData;

   wire [7:0] ctlVal = {ackEn, clkSel, intEn, pending, presc};
   wire [7:0] statVal = {mode, busy, soutEn, arbLost, asSlave, genCall, lastBit};
   wire [7:0] ownVal = {ownAddr, 1'b0};
   wire [7:0] rdMux = selCtl ? ctlVal :
                      selStat ? statVal :
                      selOwn ? ownVal :
                      selData ? shReg : 8'h00;

   // ------------------------------------------------------------
   // clock division
   // ------------------------------------------------------------
   // srcCnt may sit above a freshly lowered limit, hence the >= compare
   wire [8:0] srcLast = clkSel ? 9'(`MMIC_DIV_SLOW - 1) : 9'(`MMIC_DIV_FAST - 1);
   wire srcTick = srcCnt >= srcLast;
   wire [3:0] half = presc >> 1;
   wire stall = pending | waitData;
   wire mIdle = mState == mmic_pkg::M_IDLE;
   wire mRun = mState == mmic_pkg::M_RUN;
   wire tick = srcTick & ~stall & ~mIdle;
   wire atTop = pcnt == presc;
   wire atHalf = pcnt == half;

   // ------------------------------------------------------------
   // bus events
   // ------------------------------------------------------------
   wire startDet = sclIn & sclPrev & sdaPrev & ~sdaIn;
   wire stopDet = sclIn & sclPrev & ~sdaPrev & sdaIn;
   wire isMaster = ~mIdle;
   wire mFall = tick & atTop & (mRun | mState == mmic_pkg::M_START);
   wire mRise = tick & atHalf & mRun;
   wire sFall = sclPrev & ~sclIn;
   wire sRise = ~sclPrev & sclIn;
   wire fallE = soutEn & engaged & (isMaster ? mFall : sFall);
   wire riseE = soutEn & engaged & (isMaster ? mRise : sRise);

   wire tx = addrPhase ? isMaster : mode[0];
   wire [7:0] newByte = {shReg[6:0], sdaIn};
   wire addrHit = newByte[7:1] == ownAddr;
   wire gcHit = newByte == 8'h00;
   wire slvAck = ~isMaster & (asSlave | genCall) & ackEn;
   wire ackDrive = addrPhase ? slvAck : (~tx & ackEn);
   wire arbFail = isMaster & tx & ~sdaLow & ~sdaIn;
   wire resume = stallQ & ~stall & engaged & soutEn;
   wire startOk = wByte[`MMIC_STAT_BUSY] & wByte[7] & wByte[`MMIC_STAT_SOUT] & ~busy & mIdle;

   // ------------------------------------------------------------
   // pins and interrupt
   // ------------------------------------------------------------
   // open-drain: only ever pull low
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = mSclLow | (engaged & stall);
   assign sdaOe = sdaLow;
   assign irq = pending & intEn;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         busy <= 1'b0;
      end else begin
         sclPrev <= sclIn;
         sdaPrev <= sdaIn;
         if (startDet) begin
            busy <= 1'b1;
         end else if (stopDet) begin
            busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || srcTick) begin
         srcCnt <= 9'h000;
      end else begin
         srcCnt <= srcCnt + 9'h001;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         readData <= 32'h0000_0000;
      end else begin
         readData <= busReq.rd ? {24'h00_0000, rdMux} : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // registers, master sequencer and byte engine
   // ------------------------------------------------------------
   // later assignments in this block win, so hardware sets beat software clears
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {ackEn, clkSel, intEn, pending, presc} <= `MMIC_CTL_RESET;
         {mode, soutEn, arbLost, asSlave, genCall, lastBit} <= 7'h00;
         ownAddr <= `MMIC_OWN_RESET;
         shReg <= `MMIC_DATA_RESET;
         mState <= mmic_pkg::M_IDLE;
         bitCnt <= 4'h0;
         pcnt <= 4'h0;
         mSclLow <= 1'b0;
         sdaLow <= 1'b0;
         engaged <= 1'b0;
         addrPhase <= 1'b0;
         waitData <= 1'b0;
         stopReq <= 1'b0;
         stallQ <= 1'b0;
      end else begin
         stallQ <= stall;
         if (wrCtl) begin
            ackEn <= wByte[`MMIC_CTL_ACK];
            clkSel <= wByte[`MMIC_CTL_CLKSEL];
            intEn <= wByte[`MMIC_CTL_INTEN];
            presc <= wByte[`MMIC_CTL_PRESC];
            if (!wByte[`MMIC_CTL_PEND]) begin
               pending <= 1'b0;
            end
         end
         if (wrStat) begin
            mode <= wByte[`MMIC_STAT_MODE];
            soutEn <= wByte[`MMIC_STAT_SOUT];
            if (startOk) begin
               mState <= mmic_pkg::M_START;
               sdaLow <= 1'b1;
               pcnt <= 4'h0;
               bitCnt <= 4'h0;
               addrPhase <= 1'b1;
               engaged <= 1'b1;
               arbLost <= 1'b0;
               waitData <= 1'b0;
            end
            if (!wByte[`MMIC_STAT_BUSY] && !mIdle) begin
               stopReq <= 1'b1;
               waitData <= 1'b0;
            end
         end
         if (wrOwn && !soutEn) begin
            ownAddr <= wByte[7:1];
         end
         if (wrData && soutEn) begin
            shReg <= wByte;
            if (tx) begin
               waitData <= 1'b0;
            end
         end
         if (rdData && !tx) begin
            waitData <= 1'b0;
         end
         if (startDet || stopDet) begin
            asSlave <= 1'b0;
            genCall <= 1'b0;
         end
         if (startDet && mIdle && soutEn) begin
            engaged <= 1'b1;
            addrPhase <= 1'b1;
            bitCnt <= 4'h0;
         end
         if (stopDet && mIdle) begin
            engaged <= 1'b0;
         end

         // master clock: low for half+1 ticks, high for the rest of presc+1
         if (tick) begin
            pcnt <= atTop ? 4'h0 : pcnt + 4'h1;
         end
         case (mState)
            mmic_pkg::M_IDLE: begin
               mSclLow <= 1'b0;
            end
            mmic_pkg::M_START: begin
               if (tick && atTop) begin
                  mState <= mmic_pkg::M_RUN;
                  mSclLow <= 1'b1;
               end
            end
            mmic_pkg::M_RUN: begin
               if (tick && atTop) begin
                  mSclLow <= 1'b1;
               end else if (tick && atHalf) begin
                  mSclLow <= 1'b0;
               end
            end
            mmic_pkg::M_STOP: begin
               if (tick && atHalf) begin
                  mSclLow <= 1'b0;
               end
               if (tick && atTop) begin
                  sdaLow <= 1'b0;
                  mState <= mmic_pkg::M_IDLE;
                  engaged <= 1'b0;
               end
            end
            default: begin
               mState <= mmic_pkg::M_IDLE;
            end
         endcase

         // first bit of the next byte goes out as the hold is released
         if (resume) begin
            sdaLow <= tx & ~shReg[7];
         end
         if (stopReq && mRun && mSclLow && !stall && bitCnt == 4'h0) begin
            sdaLow <= 1'b1;
            mState <= mmic_pkg::M_STOP;
            pcnt <= 4'h0;
            stopReq <= 1'b0;
         end

         if (fallE) begin
            if (bitCnt < 4'h8) begin
               sdaLow <= tx & ~shReg[7];
            end else if (bitCnt == 4'h8) begin
               sdaLow <= ackDrive;
            end else begin
               sdaLow <= 1'b0;
               bitCnt <= 4'h0;
               addrPhase <= 1'b0;
               pending <= 1'b1;
               waitData <= 1'b1;
            end
         end

         if (riseE) begin
            if (bitCnt < 4'h8) begin
               shReg <= newByte;
               bitCnt <= bitCnt + 4'h1;
               if (bitCnt == 4'h7 && addrPhase && !isMaster) begin
                  if (addrHit) begin
                     asSlave <= 1'b1;
                     mode <= {1'b0, newByte[0]};
                  end
                  if (gcHit) begin
                     genCall <= 1'b1;
                  end
                  if (!addrHit && !gcHit) begin
                     engaged <= 1'b0;
                  end
               end
               if (arbFail) begin
                  arbLost <= 1'b1;
                  pending <= 1'b1;
                  mState <= mmic_pkg::M_IDLE;
                  mSclLow <= 1'b0;
                  engaged <= 1'b0;
                  mode <= 2'h0;
                  stopReq <= 1'b0;
               end
            end else if (bitCnt == 4'h8) begin
               lastBit <= sdaIn;
               bitCnt <= 4'h9;
            end
         end
      end
   end

endmodule

`default_nettype wire

// >>> verification/mmic_slave_model.sv
// slave partner on the shared two-wire bus: counts bits, captures bytes, answers the ack slot
`timescale 1ns/1ps
`default_nettype none

module mmic_slave_model (
   input wire logic core_clk,
   input wire logic scl,
   input wire logic sda,
   input wire logic ackOn,
   output logic ackPull = 1'b0,
   output logic [7:0] rxByte = 8'h00
);
   // ----
   // bit counter and ack
   // ----
   logic sclQ = 1'b1;
   logic sdaQ = 1'b1;
   logic [3:0] bitCnt = 4'h0;

   // lines sampled on the core clock; a falling data line under a high clock is a start
   always @(posedge core_clk) begin
      sclQ <= scl;
      sdaQ <= sda;
      if (scl && sclQ && sdaQ && !sda) begin
         bitCnt <= 4'h0;
      end else if (scl && !sclQ && bitCnt < 4'h8) begin
         rxByte <= {rxByte[6:0], sda};
         bitCnt <= bitCnt + 4'h1;
      end else if (!scl && sclQ && bitCnt == 4'h8) begin
         ackPull <= ackOn;
         bitCnt <= 4'h9;
      end else if (!scl && sclQ && bitCnt == 4'h9) begin
         ackPull <= 1'b0;
         bitCnt <= 4'h0;
      end
   end
endmodule

`default_nettype wire

// >>> verification/mmic_regs_asserts.sv
// concurrent checks on the register port and line enables of the two-wire controller
`include "mmic_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mmic_regs_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire mmic_pkg::mmic_bus_req_t busReq,
   input wire logic [31:0] readData,
   input wire logic sclIn,
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic irq
);
   // ----
   // shadow of software writes
   // ----
   logic soutOn;
   logic intOn;
   wire statWr = busReq.wr && busReq.addr == `MMIC_STAT_ADDR;
   wire ctlWr = busReq.wr && busReq.addr == `MMIC_CTL_ADDR;
   wire ctlRd = busReq.rd && busReq.addr == `MMIC_CTL_ADDR;
   wire statRd = busReq.rd && busReq.addr == `MMIC_STAT_ADDR;
   wire mapped = busReq.addr[31:4] == 28'h5400000 && busReq.addr[1:0] == 2'h0;
   wire linesIdle = !sclOe && !sdaOe;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         soutOn <= 1'b0;
         intOn <= 1'b0;
      end else begin
         if (statWr) soutOn <= busReq.wdata[4];
         if (ctlWr) intOn <= busReq.wdata[5];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ----
   // assertions
   // ----
   read_idle_a: assert property (!$past(busReq.rd) |-> readData == 32'h0)
      else $error("read data not zero outside its slot");
   read_upper_a: assert property (busReq.rd |=> readData[31:8] == 24'h0)
      else $error("upper read bits not zero");
   unmapped_zero_a: assert property (busReq.rd && !mapped |=> readData == 32'h0)
      else $error("unmapped read not zero");
   own_bit0_a: assert property (busReq.rd && busReq.addr == `MMIC_OWN_ADDR |=> !readData[0])
      else $error("own address bit 0 not zero");
   ctl_mirror_a: assert property (ctlWr ##2 ctlRd |=>
      readData[7:5] == $past(busReq.wdata[7:5], 3) && readData[3:0] == $past(busReq.wdata[3:0], 3))
      else $error("control fields not as written");
   irq_enable_a: assert property (irq |-> intOn)
      else $error("request raised while disabled");
   pend_clear_a: assert property (ctlWr && !busReq.wdata[4] && irq |=> !irq)
      else $error("pending not cleared by zero write");
   sout_gate_a: assert property (!soutOn && !(statWr && busReq.wdata[4]) && linesIdle |=> linesIdle)
      else $error("line driven with serial output off");
   start_cause_a: assert property ($rose(sdaOe) && sclIn |-> $past(statWr && busReq.wdata[5]))
      else $error("start without start request");
   busy_read_a: assert property (statRd && sclOe |=> readData[5])
      else $error("busy clear during transfer");

   start_c: cover property ($rose(sdaOe) && !sclOe);
   pend_c: cover property ($rose(irq));
   busy_c: cover property (statRd && sclOe);
endmodule

bind mmic_regs mmic_regs_asserts mmic_regs_asserts_i (
   .core_clk(core_clk), .rst(rst), .busReq(busReq), .readData(readData),
   .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq)
);

`default_nettype wire

// >>> verification/mmic_regs_tb_top.sv
// testbench top: register traffic and master transfers against a slave model, arbitration and slave addressing driven by the bench
`include "mmic_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mmic_regs_tb_top;
   localparam logic [31:0] aCtl = `MMIC_CTL_ADDR;
   localparam logic [31:0] aStat = `MMIC_STAT_ADDR;
   localparam logic [31:0] aOwn = `MMIC_OWN_ADDR;
   localparam logic [31:0] aData = `MMIC_DATA_ADDR;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   mmic_pkg::mmic_bus_req_t busReq = '0;
   logic [31:0] readData;
   logic sclOe, sdaOe, irq, ackPull;
   logic rdSeen = 1'b0;
   logic ackOn = 1'b1;
   logic tbPull = 1'b0;
   logic tbScl = 1'b0;
   logic seenOe = 1'b0;
   logic [7:0] adr;
   int j;
   logic [7:0] rxByte, own, ctl;
   logic [15:0] note;
   logic [15:0] expQ[$];
   logic [31:0] cyc = 32'h0;
   logic [31:0] w0;
   logic [31:0] seed = 32'hb7c2154a;
   int n_errors = 0;
   int comparisons = 0;
   int i;
   // open drain with pull-ups: a line is low while any party pulls it
   wire scl = !(sclOe || tbScl);
   wire sda = !(sdaOe || ackPull || tbPull);

   always #4 core_clk = !core_clk;
   always @(posedge core_clk) cyc <= cyc + 32'h1;

   mmic_regs mmic_regs_i (
      .core_clk(core_clk), .rst(rst), .busReq(busReq), .readData(readData),
      .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .irq(irq)
   );
   mmic_slave_model mmic_slave_model_i (
      .core_clk(core_clk), .scl(scl), .sda(sda), .ackOn(ackOn), .ackPull(ackPull), .rxByte(rxByte)
   );

   // ----
   // shared tasks
   // ----
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // a leading edge keeps two transfers from assigning the strobe in one time step
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge core_clk);
      busReq <= '{a, {24'h0, d}, 1'b1, 1'b0};
      @(posedge core_clk);
      busReq.wr <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge core_clk);
      busReq <= '{a, 32'h0, 1'b0, 1'b1};
      expQ.push_back({m, e});
      @(posedge core_clk);
      busReq.rd <= 1'b0;
   endtask

   // bench as a second master: data changes only while the clock line is low
   task automatic tbBit(input logic b);
      tbPull <= !b;
      repeat (4) @(posedge core_clk);
      tbScl <= 1'b0;
      repeat (4) @(posedge core_clk);
      seenOe = sdaOe;
      tbScl <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic waitLvl(ref logic s, input logic v);
      int k;
      for (k = 0; k < 20000; k++) begin
         @(negedge core_clk);
         if (s === v) break;
      end
      if (s !== v) begin
         n_errors++;
         print_verdict();
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rdSeen) begin
         note = expQ.pop_front();
         chk(readData & {24'hffffff, note[15:8]}, {24'h0, note[7:0]}, "readData");
      end
      rdSeen <= busReq.rd;
   end

   // ----
   // scenarios
   // ----
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      wr(aCtl + 32'h10, 8'hff);
      for (i = 0; i < 5; i++) rd(aCtl + 32'(4 * i), 8'h00, 8'hff);
      wr(aCtl, 8'hf2);
      rd(aCtl, 8'he2, 8'hff);
      seed = xs(seed);
      own = seed[7:0];
      wr(aOwn, own);
      wr(aData, own);
      rd(aOwn, {own[7:1], 1'b0}, 8'hff);
      rd(aData, 8'h00, 8'hff);
      for (i = 0; i < 4; i++) begin
         wr(aStat, {i[1:0], 6'h00});
         rd(aStat, {i[1:0], 6'h00}, 8'hff);
      end
      wr(aStat, 8'h10);
      wr(aOwn, ~own);
      wr(aData, own);
      rd(aOwn, {own[7:1], 1'b0}, 8'hff);
      rd(aData, own, 8'hff);
      $display("registers done");
      for (i = 0; i < 2; i++) begin
         seed = xs(seed);
         ctl = {1'b1, i[0], 1'b1, 1'b0, 4'h2};
         wr(aCtl, ctl);
         wr(aData, {seed[7:1], 1'b0});
         wr(aStat, 8'hf0);
         waitLvl(sclOe, 1'b1);
         w0 = cyc;
         waitLvl(sclOe, 1'b0);
         waitLvl(sclOe, 1'b1);
         chk(cyc - w0, 32'd48 << (5 * i), "sclPeriod");
         waitLvl(irq, 1'b1);
         chk({31'h0, sclOe}, 32'h1, "sclHeld");
         chk({24'h0, rxByte}, {24'h0, seed[7:1], 1'b0}, "wireByte");
         rd(aStat, 8'hf0, 8'hf9);
         ackOn <= 1'b0;
         // first pass clears pending before new data, second loads data first
         if (i == 0) wr(aCtl, ctl);
         else wr(aData, seed[15:8]);
         repeat (60) @(negedge core_clk);
         chk({31'h0, sclOe}, 32'h1, "sclHeld");
         if (i == 0) wr(aData, seed[15:8]);
         else wr(aCtl, ctl);
         waitLvl(irq, 1'b1);
         chk({24'h0, rxByte}, {24'h0, seed[15:8]}, "wireByte");
         rd(aStat, 8'hf1, 8'hf9);
         wr(aStat, 8'hd0);
         wr(aCtl, ctl);
         waitLvl(sdaOe, 1'b1);
         waitLvl(sdaOe, 1'b0);
         repeat (8) @(posedge core_clk);
         rd(aStat, 8'h00, 8'h20);
         ackOn <= 1'b1;
         $display("transfer done");
      end
      wr(aData, 8'h80);
      wr(aStat, 8'hf0);
      tbPull <= 1'b1;
      waitLvl(irq, 1'b1);
      rd(aStat, 8'h18, 8'hd8);
      wr(aCtl, ctl);
      tbPull <= 1'b0;
      wr(aStat, 8'he0);
      repeat (200) @(negedge core_clk);
      chk({30'h0, sclOe, sdaOe}, 32'h0, "linesIdle");
      rd(aStat, 8'h00, 8'h30);
      $display("arbitration done");
      // block as addressed slave: own address first, then general call
      wr(aStat, 8'h10);
      ackOn <= 1'b0;
      for (i = 0; i < 2; i++) begin
         adr = (i == 0) ? {own[7:1], 1'b0} : 8'h00;
         tbPull <= 1'b1;
         repeat (4) @(posedge core_clk);
         tbScl <= 1'b1;
         repeat (4) @(posedge core_clk);
         for (j = 7; j >= 0; j--) tbBit(adr[j]);
         tbBit(1'b1);
         chk({31'h0, seenOe}, 32'h1, "slaveAck");
         chk({31'h0, irq}, 32'h1, "slavePend");
         rd(aStat, {5'h06, adr[7:1] == own[7:1], adr == 8'h00, 1'b0}, 8'hf7);
         rd(aData, adr, 8'hff);
         wr(aCtl, ctl);
         tbPull <= 1'b1;
         repeat (4) @(posedge core_clk);
         tbScl <= 1'b0;
         repeat (4) @(posedge core_clk);
         tbPull <= 1'b0;
         repeat (4) @(posedge core_clk);
         rd(aStat, 8'h00, 8'h26);
      end
      $display("slave done");
      // let the last read result reach the compare before the verdict
      repeat (2) @(posedge core_clk);
      chk(expQ.size(), 32'h0, "readsLeft");
      print_verdict();
   end
endmodule

`default_nettype wire
